// ---- src/i2c_cc_cfg.sv ----
// control channel configuration registers, remap and bus watchdog
//
// Contract
// R1 - forward sequence error sets flag bit 7
// R2 - clear bit 6 clears flag while one
// R3 - bits 4:3 pick data delay 250-400ns
// R4 - bit 2 rejects remote writes to registers
// R5 - watchdog expires 1s, or 50us when fast
// R6 - bit 0 stops watchdog entirely
// R7 - data high and idle means bus free
// R8 - data low at expiry drives nine clocks
// R9 - identifier auto-loads, read-only, unless frozen
// R10 - frozen identifier takes software written value
// R11 - target entries hold physical address 7:1
// R12 - alias entries hold local address 7:1
// R13 - pass-through forwards alias matches remotely
// R14 - sequence flag sticky until cleared
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module i2c_cc_cfg #(
	parameter int WD_SLOW_CYC = i2c_cc_cfg_pkg::WD_SLOW_CYC,
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// control channel events
	input wire logic seq_err_pulse,
	input wire logic far_id_load,
	input wire logic [6:0] far_id_val,
	// register writes arriving from the serializer side
	input wire logic rmt_wr_en,
	input wire logic [7:0] rmt_wr_idx,
	input wire logic [7:0] rmt_wr_data,
	output logic rmt_wr_reject,
	// local transaction remap
	input wire logic loc_addr_valid,
	input wire logic [6:0] loc_addr,
	output logic fwd_valid,
	output logic [6:0] fwd_addr,
	// i2c pins and local target engine
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_b,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_b,
	input wire logic sda_low_req,
	output logic bus_free
);
	import i2c_cc_cfg_pkg::*;

	function automatic logic mapped(input logic [7:0] i);
		return (i == IDX_GEN_CFG) || (i == IDX_CTRL2) ||
			(i == IDX_IDENT) || (i == IDX_TGT0) || (i == IDX_TGT1) ||
			(i == IDX_ALIAS0) || (i == IDX_ALIAS1);
	endfunction

	// a zero alias is treated as unused so it never catches general call
	function automatic logic alias_hit(input logic [6:0] a,
		input logic [6:0] al);
		return (al != 7'h00) && (a == al);
	endfunction

	// synchronisers
	logic scl_meta_ff, scl_sync_ff, sda_meta_ff, sda_sync_ff;

	// register state
	logic pass_ff, nxt_pass;
	logic seq_err_ff, nxt_seq_err;
	logic seq_clr_ff, nxt_seq_clr;
	logic [1:0] dly_ff, nxt_dly;
	logic blk_ff, nxt_blk;
	logic fast_ff, nxt_fast;
	logic off_ff, nxt_off;
	logic [6:0] far_id_ff, nxt_far_id;
	logic hold_far_ident_ff, nxt_hold_far_ident;
	logic [6:0] tgt0_ff, nxt_tgt0, tgt1_ff, nxt_tgt1;
	logic [6:0] alias0_ff, nxt_alias0, alias1_ff, nxt_alias1;

	// bus answer and event outputs
	logic [31:0] prdata_ff;
	logic pready_ff, pslverr_ff;
	logic reject_ff, fwd_valid_ff;
	logic [6:0] fwd_addr_ff;
	logic od_low_ff;
	logic [7:0] rd_byte;

	// apb decode
	wire [7:0] idx = paddr[9:2];
	wire addr_ok = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
	wire apb_hit = addr_ok && mapped(idx);
	wire apb_setup = psel & ~penable;
	wire apb_wr = psel & penable & pready_ff & pwrite & apb_hit &
		pstrb[0];

	// one write port shared by apb and the serializer side; apb first
	wire rmt_ok = rmt_wr_en & ~blk_ff & ~apb_wr & mapped(rmt_wr_idx); // [R4]
	wire wr_go = apb_wr | rmt_ok;
	wire [7:0] wr_idx = apb_wr ? idx : rmt_wr_idx;
	wire [7:0] wr_dat = apb_wr ? pwdata[7:0] : rmt_wr_data;
	wire wr_gen = wr_go && (wr_idx == IDX_GEN_CFG);
	wire wr_c2 = wr_go && (wr_idx == IDX_CTRL2);
	wire wr_id = wr_go && (wr_idx == IDX_IDENT);
	wire wr_tgt0 = wr_go && (wr_idx == IDX_TGT0);
	wire wr_tgt1 = wr_go && (wr_idx == IDX_TGT1);
	wire wr_alias0 = wr_go && (wr_idx == IDX_ALIAS0);
	wire wr_alias1 = wr_go && (wr_idx == IDX_ALIAS1);
	wire [6:0] wr_addr = wr_dat[7:ADDR_LSB];

	// the identifier field opens to software once frozen, or in the
	// same write that freezes it
	wire id_sw = wr_id & (hold_far_ident_ff | wr_dat[HOLD_BIT]); // [R10]
	wire id_auto = far_id_load & ~hold_far_ident_ff; // [R9]

	// remap decode
	wire hit0 = pass_ff & alias_hit(loc_addr, alias0_ff); // [R13]
	wire hit1 = pass_ff & alias_hit(loc_addr, alias1_ff); // [R13]

	assign nxt_pass = wr_gen ? wr_dat[GEN_PASS_BIT] : pass_ff;
	// set wins over the clear; the flag stays up otherwise
	assign nxt_seq_err = seq_err_pulse ? 1'b1 : // [R1]
		(seq_clr_ff ? 1'b0 : seq_err_ff); // [R2] [R14]
	assign nxt_seq_clr = wr_c2 ? wr_dat[C2_SEQ_CLR_BIT] : seq_clr_ff; // [R2]
	assign nxt_dly = wr_c2 ? wr_dat[C2_DLY_LSB+:2] : dly_ff;
	assign nxt_blk = wr_c2 ? wr_dat[C2_BLK_BIT] : blk_ff;
	assign nxt_fast = wr_c2 ? wr_dat[C2_FAST_BIT] : fast_ff;
	assign nxt_off = wr_c2 ? wr_dat[C2_OFF_BIT] : off_ff;
	assign nxt_hold_far_ident = wr_id ? wr_dat[HOLD_BIT] :
		hold_far_ident_ff;
	assign nxt_far_id = id_sw ? wr_addr : // [R10]
		(id_auto ? far_id_val : far_id_ff); // [R9]
	assign nxt_tgt0 = wr_tgt0 ? wr_addr : tgt0_ff; // [R11]
	assign nxt_tgt1 = wr_tgt1 ? wr_addr : tgt1_ff; // [R11]
	assign nxt_alias0 = wr_alias0 ? wr_addr : alias0_ff; // [R12]
	assign nxt_alias1 = wr_alias1 ? wr_addr : alias1_ff; // [R12]

	// read view; reserved bits read zero
	always_comb begin
		rd_byte = 8'h00;
		case (idx)
			IDX_GEN_CFG: rd_byte[GEN_PASS_BIT] = pass_ff;
			IDX_CTRL2: rd_byte = {seq_err_ff, seq_clr_ff, 1'b0, dly_ff,
				blk_ff, fast_ff, off_ff};
			IDX_IDENT: rd_byte = {far_id_ff, hold_far_ident_ff};
			IDX_TGT0: rd_byte = {tgt0_ff, 1'b0};
			IDX_TGT1: rd_byte = {tgt1_ff, 1'b0};
			IDX_ALIAS0: rd_byte = {alias0_ff, 1'b0};
			IDX_ALIAS1: rd_byte = {alias1_ff, 1'b0};
			default: rd_byte = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_meta_ff <= 1'b1;
			scl_sync_ff <= 1'b1;
			sda_meta_ff <= 1'b1;
			sda_sync_ff <= 1'b1;
		end else begin
			scl_meta_ff <= scl_in;
			scl_sync_ff <= scl_meta_ff;
			sda_meta_ff <= sda_in;
			sda_sync_ff <= sda_meta_ff;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pass_ff <= RST_GEN_CFG[GEN_PASS_BIT];
			seq_err_ff <= RST_CTRL2[C2_SEQ_ERR_BIT];
			seq_clr_ff <= RST_CTRL2[C2_SEQ_CLR_BIT];
			dly_ff <= RST_CTRL2[C2_DLY_LSB+:2];
			blk_ff <= RST_CTRL2[C2_BLK_BIT];
			fast_ff <= RST_CTRL2[C2_FAST_BIT];
			off_ff <= RST_CTRL2[C2_OFF_BIT];
			far_id_ff <= RST_IDENT[7:ADDR_LSB];
			hold_far_ident_ff <= RST_IDENT[HOLD_BIT];
			tgt0_ff <= RST_TGT[7:ADDR_LSB];
			tgt1_ff <= RST_TGT[7:ADDR_LSB];
			alias0_ff <= RST_ALIAS[7:ADDR_LSB];
			alias1_ff <= RST_ALIAS[7:ADDR_LSB];
		end else begin
			pass_ff <= nxt_pass;
			seq_err_ff <= nxt_seq_err;
			seq_clr_ff <= nxt_seq_clr;
			dly_ff <= nxt_dly;
			blk_ff <= nxt_blk;
			fast_ff <= nxt_fast;
			off_ff <= nxt_off;
			far_id_ff <= nxt_far_id;
			hold_far_ident_ff <= nxt_hold_far_ident;
			tgt0_ff <= nxt_tgt0;
			tgt1_ff <= nxt_tgt1;
			alias0_ff <= nxt_alias0;
			alias1_ff <= nxt_alias1;
		end
	end

	// answer in the first access cycle; read data settle during setup
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
			prdata_ff <= 32'h0000_0000;
		end else begin
			pready_ff <= apb_setup;
			pslverr_ff <= apb_setup & ~apb_hit;
			if (apb_setup) begin
				prdata_ff <= apb_hit ? {24'h00_0000, rd_byte} :
					32'h0000_0000;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			reject_ff <= 1'b0;
			fwd_valid_ff <= 1'b0;
			fwd_addr_ff <= 7'h00;
			od_low_ff <= 1'b0;
		end else begin
			reject_ff <= rmt_wr_en & ~rmt_ok; // [R4]
			fwd_valid_ff <= loc_addr_valid & (hit0 | hit1); // [R13]
			if (loc_addr_valid & (hit0 | hit1)) begin
				fwd_addr_ff <= hit0 ? tgt0_ff : tgt1_ff; // [R11]
			end
			od_low_ff <= 1'b0;
		end
	end

	bus_watchdog #(
		.SLOW_CYC(WD_SLOW_CYC),
		.CNT_W(25)
	) u_watchdog (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.scl_i(scl_sync_ff),
		.sda_i(sda_sync_ff),
		.fast(fast_ff), // [R5]
		.off(off_ff), // [R6]
		.bus_free(bus_free),
		.scl_oe_b(scl_oe_b)
	);

	sda_delay u_sda_delay (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.scl_i(scl_sync_ff),
		.sda_low_req(sda_low_req),
		.dly_sel(dly_ff), // [R3]
		.sda_oe_b(sda_oe_b)
	);

	assign prdata = prdata_ff;
	assign pready = pready_ff;
	assign pslverr = pslverr_ff;
	assign rmt_wr_reject = reject_ff;
	assign fwd_valid = fwd_valid_ff;
	assign fwd_addr = fwd_addr_ff;
	// open-drain pins only ever pull low
	assign scl_out = od_low_ff;
	assign sda_out = od_low_ff;
endmodule // i2c_cc_cfg
`default_nettype wire

// ---- inc/i2c_cc_cfg_pkg.sv ----
// constants and types shared by the control channel configuration block
package i2c_cc_cfg_pkg;
	localparam int CLK_PERIOD_NS = 40;

	// register indices; the apb byte address is four times the index
	localparam logic [7:0] IDX_GEN_CFG = 8'h03;
	localparam logic [7:0] IDX_CTRL2 = 8'h06;
	localparam logic [7:0] IDX_IDENT = 8'h07;
	localparam logic [7:0] IDX_TGT0 = 8'h08;
	localparam logic [7:0] IDX_TGT1 = 8'h09;
	localparam logic [7:0] IDX_ALIAS0 = 8'h10;
	localparam logic [7:0] IDX_ALIAS1 = 8'h11;

	// field positions
	localparam int GEN_PASS_BIT = 3;
	localparam int C2_SEQ_ERR_BIT = 7;
	localparam int C2_SEQ_CLR_BIT = 6;
	localparam int C2_DLY_LSB = 3;
	localparam int C2_BLK_BIT = 2;
	localparam int C2_FAST_BIT = 1;
	localparam int C2_OFF_BIT = 0;
	localparam int ADDR_LSB = 1;
	localparam int HOLD_BIT = 0;

	// reset values
	localparam logic [7:0] RST_GEN_CFG = 8'h00;
	localparam logic [7:0] RST_CTRL2 = 8'h00;
	localparam logic [7:0] RST_IDENT = 8'h00;
	localparam logic [7:0] RST_TGT = 8'h00;
	localparam logic [7:0] RST_ALIAS = 8'h00;

	// timing
	localparam int SDA_DLY_BASE_NS = 250;
	localparam int SDA_DLY_STEP_NS = 50;
	localparam int WD_SLOW_S = 1;
	localparam int WD_FAST_US = 50;
	localparam int REC_HALF_NS = 5000;
	localparam int WD_SLOW_CYC = WD_SLOW_S * 1000000000 / CLK_PERIOD_NS;
	localparam int WD_FAST_CYC = WD_FAST_US * 1000 / CLK_PERIOD_NS;
	localparam int REC_HALF_CYC = REC_HALF_NS / CLK_PERIOD_NS;
	localparam logic [3:0] REC_PULSES = 4'h9;

	// least clock cycles for a nominal data-line delay setting
	function automatic logic [3:0] sda_dly_cyc(input logic [1:0] sel);
		int ns;
		ns = SDA_DLY_BASE_NS + SDA_DLY_STEP_NS * int'(sel);
		return 4'((ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	endfunction

	typedef enum logic [2:0] {
		WD_WATCH = 3'b001,
		WD_PULL = 3'b010,
		WD_LET = 3'b100
	} wd_state_t;
endpackage

// ---- src/bus_watchdog.sv ----
// i2c bus watchdog with free-bus detection and nine-clock recovery
`timescale 1ns/1ps
`default_nettype none
module bus_watchdog #(
	parameter int SLOW_CYC = i2c_cc_cfg_pkg::WD_SLOW_CYC,
	parameter int CNT_W = 25
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// synchronised bus levels
	input wire logic scl_i,
	input wire logic sda_i,
	// control
	input wire logic fast,
	input wire logic off,
	// results
	output logic bus_free,
	output logic scl_oe_b
);
	import i2c_cc_cfg_pkg::*;

	wd_state_t state_ff, nxt_state;
	logic [CNT_W-1:0] cnt_ff, nxt_cnt;
	logic [3:0] pulse_ff, nxt_pulse;
	logic scl_prev_ff, sda_prev_ff;
	logic free_ff, nxt_free;
	logic oe_b_ff, nxt_oe_b;

	wire activity = (scl_prev_ff != scl_i) || (sda_prev_ff != sda_i);
	wire [CNT_W-1:0] lim = fast ? CNT_W'(WD_FAST_CYC - 1) :
		CNT_W'(SLOW_CYC - 1);
	wire [CNT_W-1:0] half = CNT_W'(REC_HALF_CYC - 1);
	wire expired = cnt_ff == lim;
	wire half_done = cnt_ff == half;
	wire last_pulse = pulse_ff == REC_PULSES - 4'h1;

	always_comb begin
		nxt_state = state_ff;
		nxt_cnt = cnt_ff;
		nxt_pulse = pulse_ff;
		nxt_free = free_ff;
		nxt_oe_b = oe_b_ff;
		case (state_ff)
			WD_WATCH: begin
				if (off) begin // [R6]
					nxt_cnt = '0;
					nxt_free = 1'b0;
				end else if (activity) begin
					nxt_cnt = '0;
					nxt_free = 1'b0;
				end else if (expired) begin // [R5]
					if (sda_i) begin
						nxt_free = 1'b1; // [R7]
					end else begin
						nxt_state = WD_PULL; // [R8]
						nxt_cnt = '0;
						nxt_pulse = '0;
						nxt_oe_b = 1'b0;
					end
				end else begin
					nxt_cnt = cnt_ff + 1'b1;
				end
			end
			WD_PULL: begin
				if (off) begin // [R6]
					nxt_state = WD_WATCH;
					nxt_cnt = '0;
					nxt_oe_b = 1'b1;
				end else if (half_done) begin
					nxt_state = WD_LET;
					nxt_cnt = '0;
					nxt_oe_b = 1'b1;
				end else begin
					nxt_cnt = cnt_ff + 1'b1;
				end
			end
			WD_LET: begin
				if (off || (half_done && last_pulse)) begin // [R8]
					nxt_state = WD_WATCH;
					nxt_cnt = '0;
				end else if (half_done) begin
					nxt_state = WD_PULL;
					nxt_cnt = '0;
					nxt_pulse = pulse_ff + 4'h1;
					nxt_oe_b = 1'b0;
				end else begin
					nxt_cnt = cnt_ff + 1'b1;
				end
			end
			default: begin
				nxt_state = WD_WATCH;
				nxt_cnt = '0;
				nxt_oe_b = 1'b1;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_ff <= WD_WATCH;
			cnt_ff <= '0;
			pulse_ff <= '0;
			free_ff <= 1'b0;
			oe_b_ff <= 1'b1;
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			cnt_ff <= nxt_cnt;
			pulse_ff <= nxt_pulse;
			free_ff <= nxt_free;
			oe_b_ff <= nxt_oe_b;
			scl_prev_ff <= scl_i;
			sda_prev_ff <= sda_i;
		end
	end

	assign bus_free = free_ff;
	assign scl_oe_b = oe_b_ff;
endmodule // bus_watchdog
`default_nettype wire

// ---- src/sda_delay.sv ----
// delays the data-line drive after each clock-line fall
`timescale 1ns/1ps
`default_nettype none
module sda_delay (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// inputs
	input wire logic scl_i,
	input wire logic sda_low_req,
	input wire logic [1:0] dly_sel,
	// open-drain enable, low drives the line low
	output logic sda_oe_b
);
	import i2c_cc_cfg_pkg::*;

	logic scl_prev_ff;
	logic [3:0] cnt_ff;
	logic oe_b_ff;

	wire scl_fall = scl_prev_ff & ~scl_i;
	wire apply = cnt_ff == 4'h1;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			scl_prev_ff <= 1'b1;
			cnt_ff <= 4'h0;
			oe_b_ff <= 1'b1;
		end else begin
			scl_prev_ff <= scl_i;
			if (scl_fall) begin
				cnt_ff <= sda_dly_cyc(dly_sel); // [R3]
			end else if (cnt_ff != 4'h0) begin
				cnt_ff <= cnt_ff - 4'h1;
			end
			// request is sampled late so the engine may settle meanwhile
			if (apply) begin
				oe_b_ff <= ~sda_low_req; // [R3]
			end
		end
	end

	assign sda_oe_b = oe_b_ff;
endmodule // sda_delay
`default_nettype wire

// ---- verif/i2c_cc_cfg_props.sv ----
// port-level checker for the control channel configuration block
`timescale 1ns/1ps
`default_nettype none
module i2c_cc_cfg_props (
	// clock and reset
	input wire logic core_clk,
	input wire logic rst_b,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	// events
	input wire logic rmt_wr_en,
	input wire logic rmt_wr_reject,
	input wire logic loc_addr_valid,
	input wire logic fwd_valid,
	input wire logic [6:0] fwd_addr,
	// bus
	input wire logic scl_oe_b,
	input wire logic sda_in,
	input wire logic bus_free
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	a_apb_zero_wait: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	a_pready_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_err_with_ready: assert property (pslverr |-> pready && penable)
		else $error("pslverr outside access");
	a_reject_cause: assert property (
		rmt_wr_reject |-> $past(rmt_wr_en))
		else $error("reject without remote write");
	a_fwd_cause: assert property (
		fwd_valid |-> $past(loc_addr_valid))
		else $error("forward without local address");
	// the reset guard skips the edge where reset clears the address
	a_fwd_addr_hold: assert property (
		$changed(fwd_addr) && $past(rst_b) |-> fwd_valid)
		else $error("forward address moved alone");
	a_free_idle: assert property (bus_free |-> scl_oe_b)
		else $error("recovery while bus free");
	a_sda_busy: assert property (
		$fell(sda_in) |-> ##[1:4] !bus_free)
		else $error("bus free kept after data fell");
endmodule // i2c_cc_cfg_props
bind i2c_cc_cfg i2c_cc_cfg_props u_i2c_cc_cfg_props (.core_clk,
	.rst_b, .psel, .penable, .pready, .pslverr, .rmt_wr_en,
	.rmt_wr_reject, .loc_addr_valid, .fwd_valid, .fwd_addr,
	.scl_oe_b, .sda_in, .bus_free);
`default_nettype wire

// ---- verif/i2c_bus_model.sv ----
// open-drain i2c bus with pull-ups and a target able to hold lines low
`timescale 1ns/1ps
`default_nettype none
module i2c_bus_model (
	// design drives, low pulls the line
	input wire logic scl_oe_b,
	input wire logic sda_oe_b,
	// stuck or stretching target, commanded by the bench
	input wire logic scl_hold,
	input wire logic sda_hold,
	// resolved pin levels
	output logic scl_in,
	output logic sda_in
);
	// pull-ups win unless some party pulls low
	assign scl_in = scl_oe_b & ~scl_hold;
	assign sda_in = sda_oe_b & ~sda_hold;
endmodule // i2c_bus_model
`default_nettype wire

// ---- verif/i2c_cc_cfg_test.sv ----
// self-checking bench for the control channel configuration block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_total++; \
$display("ERROR t=%0t got=%h exp=%h", $time, a, e); end end
module i2c_cc_cfg_test;
	import i2c_cc_cfg_pkg::*;
	// short slow timeout keeps the run small, still above fast
	localparam int SLOW = 2000;
	logic core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic seq_err_pulse = 0, far_id_load = 0, rmt_wr_en = 0, er;
	logic [6:0] far_id_val = 0, loc_addr = 0, fwd_addr;
	logic [7:0] rmt_wr_idx = 0, rmt_wr_data = 0;
	logic loc_addr_valid = 0, sda_low_req = 0, scl_hold = 0, sda_hold = 0;
	logic pready, pslverr, rmt_wr_reject, fwd_valid, scl_in, scl_out;
	logic scl_oe_b, sda_in, sda_out, sda_oe_b, bus_free;
	int err_total = 0, checks = 0, cyc = 0;

	i2c_cc_cfg #(.WD_SLOW_CYC(SLOW)) u_i2c_cc_cfg (.core_clk, .rst_b,
		.psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata,
		.pready, .pslverr, .seq_err_pulse, .far_id_load, .far_id_val,
		.rmt_wr_en, .rmt_wr_idx, .rmt_wr_data, .rmt_wr_reject,
		.loc_addr_valid, .loc_addr, .fwd_valid, .fwd_addr, .scl_in,
		.scl_out, .scl_oe_b, .sda_in, .sda_out, .sda_oe_b, .sda_low_req,
		.bus_free);
	i2c_bus_model u_i2c_bus_model (.scl_oe_b, .sda_oe_b, .scl_hold,
		.sda_hold, .scl_in, .sda_in);

	initial begin
		forever #20 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			err_total++;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks=%0d errors=%0d", checks, err_total);
		if (err_total == 0 && checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic apb(input logic w, input logic [7:0] i, input logic [7:0] d);
		int n;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'b00, i, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge core_clk);
		penable <= 1'b1;
		n = 0;
		// no wait-state count assumed; the cycle ceiling ends a hang
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] i, input logic [7:0] e);
		apb(1'b0, i, 8'h00);
		`CHK(rd[7:0], e)
	endtask

	task automatic id_load(input logic [6:0] v);
		@(posedge core_clk);
		far_id_val <= v;
		far_id_load <= 1'b1;
		@(posedge core_clk);
		far_id_load <= 1'b0;
	endtask

	task automatic fwd(input logic [6:0] a, input logic v, input logic [6:0] e);
		@(posedge core_clk);
		loc_addr_valid <= 1'b1;
		loc_addr <= a;
		@(posedge core_clk);
		loc_addr_valid <= 1'b0;
		#1;
		`CHK(fwd_valid, v)
		if (v) `CHK(fwd_addr, e)
	endtask

	task automatic rwr(input logic [7:0] d, input logic rej);
		@(posedge core_clk);
		rmt_wr_en <= 1'b1;
		rmt_wr_idx <= IDX_TGT0;
		rmt_wr_data <= d;
		@(posedge core_clk);
		rmt_wr_en <= 1'b0;
		#1;
		`CHK(rmt_wr_reject, rej)
	endtask

	// scl activity restarts the idle count
	task automatic kick();
		@(posedge core_clk);
		scl_hold <= 1'b1;
		tick(2);
		scl_hold <= 1'b0;
	endtask

	task automatic t_regs();
		rdc(IDX_GEN_CFG, RST_GEN_CFG);
		rdc(IDX_CTRL2, RST_CTRL2);
		rdc(IDX_IDENT, RST_IDENT);
		rdc(IDX_TGT0, RST_TGT);
		rdc(IDX_TGT1, RST_TGT);
		`CHK({scl_out, sda_out}, 2'b00)
		apb(1'b0, 8'h05, 8'h00);
		`CHK(er, 1'b1)
		apb(1'b1, IDX_CTRL2, 8'hff);
		rdc(IDX_CTRL2, 8'h5f);
		apb(1'b1, IDX_TGT1, 8'hff);
		rdc(IDX_TGT1, 8'hfe);
		apb(1'b1, IDX_CTRL2, 8'h00);
		$display("regs done");
	endtask

	task automatic t_seq();
		@(posedge core_clk);
		seq_err_pulse <= 1'b1;
		@(posedge core_clk);
		seq_err_pulse <= 1'b0;
		rdc(IDX_CTRL2, 8'h80);
		tick(20);
		rdc(IDX_CTRL2, 8'h80);
		apb(1'b1, IDX_CTRL2, 8'h40);
		rdc(IDX_CTRL2, 8'h40);
		apb(1'b1, IDX_CTRL2, 8'h00);
		$display("seq done");
	endtask

	task automatic t_ident();
		id_load(7'h55);
		rdc(IDX_IDENT, 8'haa);
		apb(1'b1, IDX_IDENT, 8'h12);
		rdc(IDX_IDENT, 8'haa);
		apb(1'b1, IDX_IDENT, 8'h13);
		rdc(IDX_IDENT, 8'h13);
		id_load(7'h55);
		rdc(IDX_IDENT, 8'h13);
		$display("ident done");
	endtask

	task automatic t_remap();
		apb(1'b1, IDX_TGT0, 8'h85);
		apb(1'b1, IDX_TGT1, 8'h46);
		apb(1'b1, IDX_ALIAS0, 8'h20);
		apb(1'b1, IDX_ALIAS1, 8'h30);
		fwd(7'h10, 1'b0, 7'h00);
		apb(1'b1, IDX_GEN_CFG, 8'h08);
		fwd(7'h10, 1'b1, 7'h42);
		fwd(7'h18, 1'b1, 7'h23);
		fwd(7'h7f, 1'b0, 7'h00);
		rwr(8'h66, 1'b0);
		rdc(IDX_TGT0, 8'h66);
		apb(1'b1, IDX_CTRL2, 8'h04);
		rwr(8'h88, 1'b1);
		rdc(IDX_TGT0, 8'h66);
		$display("remap done");
	endtask

	task automatic t_wd();
		int n;
		logic prev;
		apb(1'b1, IDX_CTRL2, 8'h02);
		kick();
		tick(1200);
		`CHK(bus_free, 1'b0)
		tick(100);
		`CHK(bus_free, 1'b1)
		apb(1'b1, IDX_CTRL2, 8'h00);
		kick();
		tick(1300);
		`CHK(bus_free, 1'b0)
		tick(800);
		`CHK(bus_free, 1'b1)
		apb(1'b1, IDX_CTRL2, 8'h01);
		kick();
		tick(2200);
		`CHK(bus_free, 1'b0)
		apb(1'b1, IDX_CTRL2, 8'h02);
		sda_hold <= 1'b1;
		n = 0;
		while (scl_oe_b !== 1'b0 && n < 1400) begin
			tick(1);
			n++;
		end
		// first pull already seen; count later falls once per clock
		n = 1;
		prev = 1'b0;
		repeat (2300) begin
			@(posedge core_clk);
			if (prev && !scl_oe_b) n++;
			prev = scl_oe_b;
		end
		`CHK(n, 9)
		sda_hold <= 1'b0;
		$display("watchdog done");
	endtask

	task automatic t_dly();
		int m[4];
		int n;
		for (int s = 0; s < 4; s++) begin
			apb(1'b1, IDX_CTRL2, {3'b000, 2'(s), 3'b001});
			scl_hold <= 1'b1;
			tick(20);
			scl_hold <= 1'b0;
			tick(5);
			sda_low_req <= 1'b1;
			scl_hold <= 1'b1;
			n = 0;
			do begin
				@(posedge core_clk);
				n++;
			end while (sda_oe_b !== 1'b0 && n < 40);
			m[s] = n;
			scl_hold <= 1'b0;
			sda_low_req <= 1'b0;
		end
		for (int s = 1; s < 4; s++)
			`CHK(m[s] - m[0], (250 + 50 * s + 39) / 40 - 7)
		$display("delay done");
	endtask

	initial begin
		tick(6);
		rst_b <= 1'b1;
		tick(1);
		t_regs();
		t_seq();
		t_ident();
		t_remap();
		t_wd();
		t_dly();
		end_sim();
	end
endmodule // i2c_cc_cfg_test
`default_nettype wire
